// ==== rtl/qrd_pkg.sv ====
// package: qos rate and dscp priority register constants and carriers
`default_nettype none
package qrd_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RATE_TAG_CTRL = 8'h87;
  localparam logic [7:0] IDX_REVISION      = 8'h89;
  localparam logic [7:0] IDX_MAP_0         = 8'h90;
  localparam logic [7:0] IDX_MAP_1         = 8'h91;
  localparam logic [7:0] IDX_MAP_2         = 8'h92;
  localparam logic [7:0] IDX_MAP_LAST      = 8'h9F;
  localparam int         MAP_BYTES         = 16;
  localparam int         MAP_BITS          = 128;

  // ----------------------------------------------------------------
  // fields of rate_limit_and_tag_control and revision_identification
  // ----------------------------------------------------------------
  localparam int         POS_PERIOD_SEL    = 4;
  localparam int         POS_QUEUE_EGRESS  = 3;
  localparam int         POS_SRC_TAG_SEL   = 2;
  localparam int         POS_REVISION      = 4;
  localparam logic [1:0] RST_PERIOD_SEL    = 2'h1;
  localparam logic       RST_QUEUE_EGRESS  = 1'h0;
  localparam logic       RST_SRC_TAG_SEL   = 1'h0;
  localparam logic [1:0] RST_PRIORITY      = 2'h0;
  localparam logic [1:0] PERIOD_SEL_16     = 2'h0;
  localparam logic [1:0] PERIOD_SEL_64     = 2'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 8;
  localparam int          MS_NS            = 1000000;
  localparam int          MS_CYCLES_INT    = MS_NS / CLK_PERIOD_NS;
  localparam logic [16:0] MS_CYCLES        = 17'(MS_CYCLES_INT);
  localparam logic [8:0]  PERIOD_16_MS     = 9'h010;
  localparam logic [8:0]  PERIOD_64_MS     = 9'h040;
  localparam logic [8:0]  PERIOD_256_MS    = 9'h100;
  localparam int          NUM_PORTS        = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       is_ipv4;
    logic       is_ipv6;
    logic [7:0] tos;
  } qrd_frame_t;

  typedef struct packed {
    logic       valid;
    logic       from_tos;
    logic [1:0] prio;
  } qrd_prio_t;

  typedef struct packed {
    logic                 valid;
    logic [1:0]           src_port;
    logic [NUM_PORTS-1:0] ctrl8_insert;
    logic                 ctrl0_insert;
  } qrd_tag_req_t;

endpackage
`default_nettype wire

// ==== rtl/qrd_regs.sv ====
// module: qos rate and dscp priority register bank with its lookups
//
// Design decision made here: the Wishbone interface to the registers.
`default_nettype none

// Behaviour
// (RULE_01) window code 00/01/1x gives 16/64/256 ms
// (RULE_02) queue egress bit picks port or queue
// (RULE_03) bit set: per source-port tag via ctrl8
// (RULE_04) bit clear: tag per port ctrl0 bit2
// (RULE_05) revision in upper nibble, lower reads zero
// (RULE_06) tos top six bits pick priority entry
// (RULE_07) ipv4 and ipv6 use bits 7:2
// (RULE_08) map 0 holds codes 00-03 ascending
// (RULE_09) 0x91 holds 04-07, 0x92 from 08
// (RULE_10) every entry read/write, resets to 00
// (RULE_11) map bytes consecutive, 0x1F tops 0x97
// (RULE_12) non-ip frames bypass tos lookup
module qrd_regs #(
  parameter logic [16:0] CYCLES_PER_MS    = qrd_pkg::MS_CYCLES,
  parameter logic [3:0]  SILICON_REVISION = 4'h1  // arbitrary value
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [9:2]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // rate limit controls
  output logic      [1:0]          ingress_period_sel,
  output logic                     ingress_period_tick,
  output logic                     egress_queue_mode,
  // tag insertion query
  input  wire qrd_pkg::qrd_tag_req_t tag_req,
  output logic                     tag_valid,
  output logic                     tag_insert,
  // frame classification
  input  wire qrd_pkg::qrd_frame_t frame_in,
  output qrd_pkg::qrd_prio_t       prio_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                          ack;
    logic [31:0]                   rdata;
    logic [1:0]                    period_sel;
    logic                          queue_egress;
    logic                          src_tag_sel;
    logic [qrd_pkg::MAP_BITS-1:0]  map;
    logic [16:0]                   ms_cnt;
    logic [8:0]                    win_cnt;
    logic                          period_tick;
    qrd_pkg::qrd_prio_t            prio;
    logic                          tag_valid;
    logic                          tag_insert;
  } qrd_state_t;

  qrd_state_t s;
  qrd_state_t next_s;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] qrd_read(input qrd_state_t st, input logic [7:0] idx);
    logic [7:0] val;
    val = 8'h00;
    if (idx == qrd_pkg::IDX_RATE_TAG_CTRL) begin
      val[qrd_pkg::POS_PERIOD_SEL +: 2]  = st.period_sel;
      val[qrd_pkg::POS_QUEUE_EGRESS]     = st.queue_egress;
      val[qrd_pkg::POS_SRC_TAG_SEL]      = st.src_tag_sel;
    end else if (idx == qrd_pkg::IDX_REVISION) begin
      val[qrd_pkg::POS_REVISION +: 4]    = SILICON_REVISION; // [RULE_05]
    end else if (idx >= qrd_pkg::IDX_MAP_0 && idx <= qrd_pkg::IDX_MAP_LAST) begin
      val = st.map[{idx[3:0], 3'h0} +: 8]; // [RULE_10] [RULE_11]
    end
    return val;
  endfunction

  // ----------------------------------------------------------------
  // window length from the period code
  // ----------------------------------------------------------------
  function automatic logic [8:0] qrd_window(input logic [1:0] sel);
    logic [8:0] len;
    if (sel == qrd_pkg::PERIOD_SEL_16) begin
      len = qrd_pkg::PERIOD_16_MS;
    end else if (sel == qrd_pkg::PERIOD_SEL_64) begin
      len = qrd_pkg::PERIOD_64_MS;
    end else begin
      len = qrd_pkg::PERIOD_256_MS;
    end
    return len;
  endfunction

  // ----------------------------------------------------------------
  // table sizes
  // ----------------------------------------------------------------
  localparam int N_CODES = qrd_pkg::MAP_BITS / 2;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0] bus_idx;
  logic       bus_busy;
  logic       bus_req;
  logic       hit_ctrl;
  logic       hit_map;
  logic       wr_low;
  logic       ctrl_wr;
  logic       map_wr;
  logic [3:0] map_byte;
  logic [6:0] map_wr_bit;

  assign bus_idx    = wb_adr_i;
  assign bus_busy   = wb_cyc_i && wb_stb_i;
  assign bus_req    = bus_busy && !s.ack;
  assign hit_ctrl   = bus_idx == qrd_pkg::IDX_RATE_TAG_CTRL;
  assign hit_map    = bus_idx >= qrd_pkg::IDX_MAP_0 && bus_idx <= qrd_pkg::IDX_MAP_LAST;
  assign wr_low     = bus_req && wb_we_i && wb_sel_i[0];
  assign ctrl_wr    = wr_low && hit_ctrl;
  assign map_wr     = wr_low && hit_map;
  assign map_byte   = bus_idx[3:0];
  assign map_wr_bit = {map_byte, 3'h0};

  // ----------------------------------------------------------------
  // write data fields of the control byte
  // ----------------------------------------------------------------
  logic [1:0] wr_period_sel;
  logic       wr_queue_egress;
  logic       wr_src_tag_sel;

  assign wr_period_sel   = wb_dat_i[qrd_pkg::POS_PERIOD_SEL +: 2];
  assign wr_queue_egress = wb_dat_i[qrd_pkg::POS_QUEUE_EGRESS];
  assign wr_src_tag_sel  = wb_dat_i[qrd_pkg::POS_SRC_TAG_SEL];

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  assign rd_word = {24'h000000, qrd_read(s, bus_idx)};

  // ----------------------------------------------------------------
  // window counters
  // ----------------------------------------------------------------
  logic [8:0]  win_len;
  logic        ms_wrap;
  logic        win_wrap;
  logic [16:0] ms_cnt_inc;
  logic [8:0]  win_cnt_inc;

  assign win_len     = qrd_window(s.period_sel); // [RULE_01]
  assign ms_wrap     = s.ms_cnt >= CYCLES_PER_MS - 17'h00001;
  assign win_wrap    = s.win_cnt >= win_len - 9'h001;
  assign ms_cnt_inc  = s.ms_cnt + 17'h00001;
  assign win_cnt_inc = s.win_cnt + 9'h001;

  // ----------------------------------------------------------------
  // priority table, one entry per code point
  // ----------------------------------------------------------------
  logic [1:0] entry [N_CODES];
  logic [5:0] code_point;
  logic       frame_is_ip;
  logic       lookup_hit;
  logic [1:0] map_entry;

  for (genvar g = 0; g < N_CODES; g++) begin : g_entry
    assign entry[g] = s.map[2 * g +: 2]; // [RULE_08] [RULE_09] [RULE_11]
  end

  assign code_point  = frame_in.tos[7:2]; // [RULE_07]
  assign frame_is_ip = frame_in.is_ipv4 || frame_in.is_ipv6; // [RULE_12]
  assign lookup_hit  = frame_in.valid && frame_is_ip;
  assign map_entry   = entry[code_point]; // [RULE_06]

  // ----------------------------------------------------------------
  // tag decision inputs
  // ----------------------------------------------------------------
  logic [qrd_pkg::NUM_PORTS-1:0] src_hot;
  logic                          tag_src_bit;
  logic                          tag_by_src;

  for (genvar p = 0; p < qrd_pkg::NUM_PORTS; p++) begin : g_src
    assign src_hot[p] = tag_req.src_port == 2'(p);
  end

  assign tag_src_bit = |(src_hot & tag_req.ctrl8_insert); // [RULE_03]
  assign tag_by_src  = s.src_tag_sel;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s             = s;
    next_s.ack         = 1'b0;
    next_s.period_tick = 1'b0;
    next_s.prio        = '0;
    next_s.tag_valid   = 1'b0;
    next_s.tag_insert  = 1'b0;

    // ----------------------------------------------------------------
    // bus access: answer one cycle after the request
    // ----------------------------------------------------------------
    if (bus_req) begin
      next_s.ack   = 1'b1;
      next_s.rdata = rd_word;
    end else if (!bus_busy) begin
      next_s.rdata = 32'h00000000;
    end
    if (ctrl_wr) begin
      next_s.period_sel   = wr_period_sel;
      next_s.queue_egress = wr_queue_egress; // [RULE_02]
      next_s.src_tag_sel  = wr_src_tag_sel;
    end
    if (map_wr) begin
      next_s.map[map_wr_bit +: 8] = wb_dat_i[7:0]; // [RULE_08] [RULE_09] [RULE_10]
    end

    // ----------------------------------------------------------------
    // ingress window: 1 ms prescaler, then window count
    // ----------------------------------------------------------------
    if (ms_wrap) begin
      next_s.ms_cnt = 17'h00000;
      if (win_wrap) begin // [RULE_01]
        next_s.win_cnt     = 9'h000;
        next_s.period_tick = 1'b1;
      end else begin
        next_s.win_cnt = win_cnt_inc;
      end
    end else begin
      next_s.ms_cnt = ms_cnt_inc;
    end

    // ----------------------------------------------------------------
    // tos priority lookup, one cycle latency
    // ----------------------------------------------------------------
    if (frame_in.valid) begin
      next_s.prio.valid = 1'b1;
    end
    if (lookup_hit) begin // [RULE_12]
      next_s.prio.from_tos = 1'b1;
      next_s.prio.prio     = map_entry; // [RULE_06] [RULE_07]
    end

    // ----------------------------------------------------------------
    // tag insertion decision, one cycle latency
    // ----------------------------------------------------------------
    if (tag_req.valid) begin
      next_s.tag_valid = 1'b1;
      if (tag_by_src) begin
        next_s.tag_insert = tag_src_bit; // [RULE_03]
      end else begin
        next_s.tag_insert = tag_req.ctrl0_insert; // [RULE_04]
      end
    end

    // ----------------------------------------------------------------
    // synchronous reset
    // ----------------------------------------------------------------
    if (!rst_b) begin
      next_s.ack          = 1'b0;
      next_s.rdata        = 32'h00000000;
      next_s.period_sel   = qrd_pkg::RST_PERIOD_SEL; // [RULE_01]
      next_s.queue_egress = qrd_pkg::RST_QUEUE_EGRESS; // [RULE_02]
      next_s.src_tag_sel  = qrd_pkg::RST_SRC_TAG_SEL; // [RULE_04]
      next_s.map          = {qrd_pkg::MAP_BYTES * 4{qrd_pkg::RST_PRIORITY}}; // [RULE_10]
      next_s.ms_cnt       = 17'h00000;
      next_s.win_cnt      = 9'h000;
      next_s.period_tick  = 1'b0;
      next_s.prio         = '0;
      next_s.tag_valid    = 1'b0;
      next_s.tag_insert   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o            = s.ack;
  assign wb_dat_o            = s.rdata;
  assign ingress_period_sel  = s.period_sel;
  assign ingress_period_tick = s.period_tick;
  assign egress_queue_mode   = s.queue_egress; // [RULE_02]
  assign tag_valid           = s.tag_valid;
  assign tag_insert          = s.tag_insert;
  assign prio_out            = s.prio;

endmodule
`default_nettype wire

// ==== verif/qrd_regs_props.sv ====
// checker: bus, lookup, tag and tick properties of the register bank
`default_nettype none
module qrd_regs_props (
  // bus
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [9:2]            wb_adr_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  // controls and lookups
  input wire logic [1:0]            ingress_period_sel,
  input wire logic                  ingress_period_tick,
  input wire logic                  egress_queue_mode,
  input wire qrd_pkg::qrd_tag_req_t tag_req,
  input wire logic                  tag_valid,
  input wire logic                  tag_insert,
  input wire qrd_pkg::qrd_frame_t   frame_in,
  input wire qrd_pkg::qrd_prio_t    prio_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_next: assert property (req |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_rev_low: assert property (req && !wb_we_i && wb_adr_i == 8'h89 |=>
    wb_dat_o[3:0] == 4'h0 && wb_dat_o[31:8] == 24'h0) else $error("revision low bits");
  a_period_rst: assert property ($rose(rst_b) |-> ingress_period_sel == 2'h1)
    else $error("period reset");
  a_tick_pulse: assert property (ingress_period_tick |=> !ingress_period_tick)
    else $error("tick held");
  a_queue_write: assert property ($changed(egress_queue_mode) |->
    wb_ack_o && $past(wb_we_i)) else $error("queue mode moved");
  a_ip_lookup: assert property (frame_in.valid &&
    (frame_in.is_ipv4 || frame_in.is_ipv6) |=> prio_out.valid && prio_out.from_tos)
    else $error("ip lookup");
  a_nonip_pass: assert property (frame_in.valid &&
    !frame_in.is_ipv4 && !frame_in.is_ipv6 |=> prio_out == 4'h8) else $error("non ip lookup");
  a_tag_all: assert property (tag_req.valid && tag_req.ctrl8_insert == 4'hF &&
    tag_req.ctrl0_insert |=> tag_valid && tag_insert) else $error("tag insert");
  a_tag_none: assert property (tag_req.valid && tag_req.ctrl8_insert == 4'h0 &&
    !tag_req.ctrl0_insert |=> tag_valid && !tag_insert) else $error("tag skip");
  c_write: cover property (req && wb_we_i);
  c_tick: cover property (ingress_period_tick);
  c_tag: cover property (tag_valid && tag_insert);
endmodule
`default_nettype wire

// ==== verif/qrd_regs_bench.sv ====
// bench: self-checking test of the qos rate and dscp priority registers
`default_nettype none
module qrd_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                  ingress_period_tick, egress_queue_mode, tag_valid, tag_insert;
  logic [9:2]            wb_adr_i;
  logic [31:0]           wb_dat_i, wb_dat_o, rd;
  logic [1:0]            ingress_period_sel;
  logic [3:0]            wb_sel_i;
  qrd_pkg::qrd_tag_req_t tag_req;
  qrd_pkg::qrd_frame_t   frame_in;
  qrd_pkg::qrd_prio_t    prio_out;
  logic [7:0]            m [16];
  logic [31:0]           seed = 32'h3FA5;
  int                    n_errors, checked, cyc, n;
  // revision value is arbitrary
  qrd_regs #(.CYCLES_PER_MS(17'h0000A), .SILICON_REVISION(4'hA)) DUT (.ref_clk, .rst_b,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .ingress_period_sel, .ingress_period_tick, .egress_queue_mode, .tag_req,
    .tag_valid, .tag_insert, .frame_in, .prio_out);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] exp_prio(input logic [5:0] c);
    return m[c[5:2]][2 * c[1:0] +: 2];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic frm(input logic [1:0] kind, input logic [7:0] tos, input logic [3:0] e);
    frame_in <= {1'b1, kind, tos};
    @(posedge ref_clk);
    frame_in.valid <= 1'b0;
    @(posedge ref_clk);
    chk({28'h0, prio_out}, {28'h0, e});
  endtask
  task automatic tag(input logic [1:0] s, input logic [4:0] r, input logic e);
    tag_req <= {1'b1, s, r};
    @(posedge ref_clk);
    tag_req.valid <= 1'b0;
    @(posedge ref_clk);
    chk({30'h0, tag_valid, tag_insert}, {30'h0, 1'b1, e});
  endtask
  task automatic gap();
    n = 0;
    do @(posedge ref_clk); while (ingress_period_tick !== 1'b1);
    do begin
      @(posedge ref_clk);
      n++;
    end while (ingress_period_tick !== 1'b1);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, tag_req, frame_in} = '0;
    wb_sel_i = 4'hF;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    wb(1'b0, 8'h87, 8'h0);
    chk(rd, 32'h10);
    wb(1'b1, 8'h89, 8'hFF);
    wb(1'b0, 8'h89, 8'h0);
    chk(rd, 32'hA0);
    wb(1'b1, 8'h87, 8'hFF);
    wb(1'b0, 8'h87, 8'h0);
    chk(rd, 32'h3C);
    chk({30'h0, ingress_period_sel}, 32'h3);
    chk({31'h0, egress_queue_mode}, 32'h1);
    wb(1'b1, 8'h20, 8'h5A);
    wb(1'b0, 8'h20, 8'h0);
    chk(rd, 32'h0);
    wb_sel_i <= 4'hE;
    wb(1'b1, 8'h90, 8'hFF);
    wb_sel_i <= 4'hF;
    wb(1'b0, 8'h90, 8'h0);
    chk(rd, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, 8'h87, 8'(p << 4));
      gap();
      chk(32'(n), 32'(p == 0 ? 160 : p == 1 ? 640 : 2560));
    end
    for (int i = 0; i < 16; i++) begin
      wb(1'b0, 8'h90 + 8'(i), 8'h0);
      chk(rd, 32'h0);
      m[i] = 8'(rnd());
      wb(1'b1, 8'h90 + 8'(i), m[i]);
      wb(1'b0, 8'h90 + 8'(i), 8'h0);
      chk(rd, {24'h0, m[i]});
    end
    for (int c = 0; c < 64; c++)
      frm(2'(1 + c % 2), {6'(c), 2'(rnd())}, {2'b11, exp_prio(6'(c))});
    frm(2'b00, 8'hFC, 4'h8);
    for (int i = 0; i < 32; i++) begin
      logic [4:0] r;
      r = i < 16 ? {5{i[3]}} : 5'(rnd());
      wb(1'b1, 8'h87, {5'h0, i[2], 2'h0});
      tag(2'(i), r, i[2] ? r[1 + i[1:0]] : r[0]);
    end
    results();
  end
endmodule
bind qrd_regs qrd_regs_props u_props (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .ingress_period_sel, .ingress_period_tick,
  .egress_queue_mode, .tag_req, .tag_valid, .tag_insert, .frame_in, .prio_out);
`default_nettype wire
